// >>> gser_pkg.sv
package gser_pkg;

    // ------------------------------------------------------------
    // standard event flags: bit positions and reset value
    // ------------------------------------------------------------
    localparam int ESR_PON = 7;
    localparam int ESR_CME = 5;
    localparam int ESR_EXE = 4;
    localparam int ESR_DDE = 3;
    localparam int ESR_QYE = 2;
    localparam int ESR_OPC = 0;
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] ESR_USED = 8'hBD;
    localparam logic [7:0] ESE_RESET = 8'h00;

    // ------------------------------------------------------------
    // fault cause flags: bit positions and reset value
    // ------------------------------------------------------------
    localparam int ERR_LENGTH = 6;
    localparam int ERR_HEADER = 5;
    localparam int ERR_FORMAT = 4;
    localparam int ERR_RANGE = 3;
    localparam int ERR_NOEXEC = 2;
    localparam int ERR_LINK = 1;
    localparam int ERR_BACKUP = 0;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] ERR_USED = 8'h7F;

    // ------------------------------------------------------------
    // status byte positions and output queue shape
    // ------------------------------------------------------------
    localparam int STB_ESB = 5;
    localparam int STB_MAV = 4;
    localparam logic [7:0] STB_RESET = 8'h00;
    localparam int OQ_AW = 4;
    localparam int OQ_DEPTH = 16;
    localparam logic [OQ_AW:0] OQ_FULL = 5'h10;

    // ------------------------------------------------------------
    // decoded commands and operation-complete tracker states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_CLEAR = 3'b001,
        CMD_ESE_SET = 3'b010,
        CMD_ESE_QRY = 3'b011,
        CMD_ESR_QRY = 3'b100,
        CMD_ERR_QRY = 3'b101,
        CMD_OPC = 3'b110
    } gser_cmd_t;

    typedef enum logic {
        OPC_IDLE = 1'b0,
        OPC_WAIT = 1'b1
    } gser_opc_t;

endpackage

// >>> gser_ram_if.sv
`timescale 1ns/1ps
interface gser_ram_if;
    logic wrEn;
    logic [gser_pkg::OQ_AW-1:0] wrAddr;
    logic [7:0] wrData;
    logic rdEn;
    logic [gser_pkg::OQ_AW-1:0] rdAddr;
    logic [7:0] rdData;

    modport ctrl (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr,
        input rdData);
    modport ram (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr,
        output rdData);
endinterface

// >>> gser_queue_ram.sv
`timescale 1ns/1ps
module gser_queue_ram (
    // clock
    input wire logic clock,
    // storage port
    gser_ram_if.ram mem
);
    logic [7:0] store [gser_pkg::OQ_DEPTH];
    logic [7:0] rdData_q;

    // ------------------------------------------------------------
    // storage and registered read
    // ------------------------------------------------------------
    // no reset on the array: contents are only read after a write
    always_ff @(posedge clock) begin
        if (mem.wrEn) begin
            store[mem.wrAddr] <= mem.wrData;
        end
        if (mem.rdEn) begin
            rdData_q <= store[mem.rdAddr];
        end
    end

    assign mem.rdData = rdData_q;
endmodule

// >>> gser_nrfd_hold.sv
`timescale 1ns/1ps
module gser_nrfd_hold (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // handshake and command engine
    input wire logic handshakeStart,
    input wire logic cmdBusy,
    // bus line drive
    output logic nrfdHold
);
    logic hold_q;
    logic hold_d;

    // ------------------------------------------------------------
    // not-ready-for-data latch
    // ------------------------------------------------------------
    // the byte is accepted, then the talker is parked until idle
    always_comb begin
        hold_d = hold_q;
        if (handshakeStart && cmdBusy) begin
            hold_d = 1'b1;
        end else if (!cmdBusy) begin
            hold_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
        end
    end

    assign nrfdHold = hold_q;

    a_nrfd_stall: assert property (@(posedge clock) disable iff (!rst_b)
        (handshakeStart && cmdBusy) |=> nrfdHold)
        else $error("not-ready line dropped while command still busy");
endmodule

// >>> gser_top.sv
`timescale 1ns/1ps
// Functional notes
// - enabled event bits OR into summary bit
// - clear command empties event and fault flags; enable mask and queue kept
// - enable mask written and read back
// - event query returns flags then clears all but device error
// - power-on bit set after reset
// - length, header, format faults raise command error
// - mask write with format or range fault ignored, mask kept
// - range or not-executable raises execution error
// - internal faults raise device error until their fault flags are cleared
// - queue misuse and early addressing raise query error
// - operation complete set when work drains
// - seven fault flags feed events unmasked
// - fault query returns flags then clears them
// - message length fault at bit 6
// - unknown header fault at bit 5
// - parameter format fault at bit 4
// - value range fault at bit 3
// - not executable fault at bit 2
// - internal link fault at bit 1
// - backup store lost at bit 0
// - hold not-ready line while command busy
// - each response group ends with delimiter
// - message available tracks non-empty queue
// - summary bit lives at status bit 5
module gser_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // decoded commands from the message parser
    input wire logic cmdValid,
    input wire gser_pkg::gser_cmd_t cmdCode,
    input wire logic [7:0] cmdParam,
    // parser and engine fault strobes
    input wire logic msgLengthFault,
    input wire logic headerUnknownFault,
    input wire logic paramFormatFault,
    input wire logic valueRangeFault,
    input wire logic notExecutableFault,
    input wire logic internalLinkFault,
    input wire logic backupStoreLost,
    input wire logic talkerEarly,
    input wire logic listenerEarly,
    // engine state and bus handshake
    input wire logic opsPending,
    input wire logic cmdBusy,
    input wire logic handshakeStart,
    // measurement responses and queue readout
    input wire logic respValid,
    input wire logic [7:0] respData,
    input wire logic rdReq,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic rdDelim,
    // status outputs
    output logic [7:0] statusByte,
    output logic devEventClear,
    output logic nrfdHold
);
    gser_ram_if ramIf ();

    logic [7:0] esr_q;
    logic [7:0] esr_d;
    logic [7:0] err_q;
    logic [7:0] err_d;
    logic [7:0] ese_q;
    logic [7:0] ese_d;
    logic [7:0] stb_q;
    logic [7:0] stb_d;
    gser_pkg::gser_opc_t opc_q;
    gser_pkg::gser_opc_t opc_d;
    logic [gser_pkg::OQ_AW-1:0] wp_q;
    logic [gser_pkg::OQ_AW-1:0] wp_d;
    logic [gser_pkg::OQ_AW-1:0] rp_q;
    logic [gser_pkg::OQ_AW-1:0] rp_d;
    logic [gser_pkg::OQ_AW:0] cnt_q;
    logic [gser_pkg::OQ_AW:0] cnt_d;
    logic rdValid_q;
    logic devClr_q;
    logic [7:0] errSet;
    logic [7:0] esrSet;
    logic isClear;
    logic esrRead;
    logic errRead;
    logic pushReq;
    logic [7:0] pushData;
    logic push;
    logic pop;
    logic overflow;
    logic emptyRead;
    logic opcDone;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // sticky flag update; a set in the clearing cycle survives
    function automatic logic [7:0] stick(input logic [7:0] cur, input logic [7:0] set,
        input logic clr, input logic [7:0] used);
        stick = ((cur & ~{8{clr}}) | set) & used;
    endfunction

    function automatic logic [gser_pkg::OQ_AW-1:0] bump(input logic [gser_pkg::OQ_AW-1:0] p);
        bump = p + 4'h1;
    endfunction

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    assign isClear = cmdValid && (cmdCode == gser_pkg::CMD_CLEAR);
    assign esrRead = cmdValid && (cmdCode == gser_pkg::CMD_ESR_QRY);
    assign errRead = cmdValid && (cmdCode == gser_pkg::CMD_ERR_QRY);

    // ------------------------------------------------------------
    // output queue control
    // ------------------------------------------------------------
    // query answers take the slot; the engine must not push alongside
    always_comb begin
        pushReq = respValid;
        pushData = respData;
        if (esrRead) begin
            pushReq = 1'b1;
            pushData = esr_q;
        end else if (errRead) begin
            pushReq = 1'b1;
            pushData = err_q;
        end else if (cmdValid && (cmdCode == gser_pkg::CMD_ESE_QRY)) begin
            pushReq = 1'b1;
            pushData = ese_q;
        end
    end

    assign overflow = pushReq && (cnt_q == gser_pkg::OQ_FULL);
    assign push = pushReq && !overflow; // excess answer is lost
    assign pop = rdReq && (cnt_q != 5'h00);
    assign emptyRead = rdReq && (cnt_q == 5'h00);

    always_comb begin
        wp_d = push ? bump(wp_q) : wp_q;
        rp_d = pop ? bump(rp_q) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 5'h01;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 5'h01;
        end
    end

    assign ramIf.wrEn = push;
    assign ramIf.wrAddr = wp_q;
    assign ramIf.wrData = pushData;
    assign ramIf.rdEn = pop;
    assign ramIf.rdAddr = rp_q;

    // ------------------------------------------------------------
    // operation-complete tracker
    // ------------------------------------------------------------
    always_comb begin
        opc_d = opc_q;
        opcDone = 1'b0;
        case (opc_q)
            gser_pkg::OPC_IDLE: begin
                if (cmdValid && (cmdCode == gser_pkg::CMD_OPC)) begin
                    opc_d = gser_pkg::OPC_WAIT;
                end
            end
            gser_pkg::OPC_WAIT: begin
                if (!opsPending) begin
                    opcDone = 1'b1;
                    opc_d = gser_pkg::OPC_IDLE;
                end
            end
            default: begin
                opc_d = gser_pkg::OPC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // fault cause and standard event flags
    // ------------------------------------------------------------
    always_comb begin
        errSet = 8'h00;
        errSet[gser_pkg::ERR_LENGTH] = msgLengthFault;
        errSet[gser_pkg::ERR_HEADER] = headerUnknownFault;
        errSet[gser_pkg::ERR_FORMAT] = paramFormatFault;
        errSet[gser_pkg::ERR_RANGE] = valueRangeFault;
        errSet[gser_pkg::ERR_NOEXEC] = notExecutableFault;
        errSet[gser_pkg::ERR_LINK] = internalLinkFault;
        errSet[gser_pkg::ERR_BACKUP] = backupStoreLost;
        err_d = stick(err_q, errSet, isClear || errRead, gser_pkg::ERR_USED);
        // fault flags map straight into event bits, no enable applied
        esrSet = 8'h00;
        esrSet[gser_pkg::ESR_CME] = msgLengthFault || headerUnknownFault || paramFormatFault;
        esrSet[gser_pkg::ESR_EXE] = valueRangeFault || notExecutableFault;
        esrSet[gser_pkg::ESR_QYE] = overflow || emptyRead || talkerEarly || listenerEarly;
        esrSet[gser_pkg::ESR_OPC] = opcDone;
        esr_d = stick(esr_q, esrSet, isClear || esrRead, gser_pkg::ESR_USED);
        // device error follows its causes rather than latching
        esr_d[gser_pkg::ESR_DDE] = err_d[gser_pkg::ERR_LINK] || err_d[gser_pkg::ERR_BACKUP];
    end

    // ------------------------------------------------------------
    // enable mask and status byte
    // ------------------------------------------------------------
    // a mask write carrying a format or range fault leaves the old mask
    always_comb begin
        ese_d = ese_q;
        if (cmdValid && (cmdCode == gser_pkg::CMD_ESE_SET) && !paramFormatFault
            && !valueRangeFault) begin
            ese_d = cmdParam & gser_pkg::ESR_USED;
        end
        stb_d = 8'h00;
        stb_d[gser_pkg::STB_ESB] = |(esr_d & ese_d);
        stb_d[gser_pkg::STB_MAV] = (cnt_d != 5'h00);
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            esr_q <= gser_pkg::ESR_RESET;
            err_q <= gser_pkg::ERR_RESET;
            ese_q <= gser_pkg::ESE_RESET;
            stb_q <= gser_pkg::STB_RESET;
            opc_q <= gser_pkg::OPC_IDLE;
            wp_q <= 4'h0;
            rp_q <= 4'h0;
            cnt_q <= 5'h00;
            rdValid_q <= 1'b0;
            devClr_q <= 1'b0;
        end else begin
            esr_q <= esr_d;
            err_q <= err_d;
            ese_q <= ese_d;
            stb_q <= stb_d;
            opc_q <= opc_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdValid_q <= pop;
            devClr_q <= isClear;
        end
    end

    // ------------------------------------------------------------
    // submodules and outputs
    // ------------------------------------------------------------
    gser_queue_ram uRam (
        .clock(clock),
        .mem(ramIf.ram)
    );

    gser_nrfd_hold uNrfd (
        .clock(clock),
        .rst_b(rst_b),
        .handshakeStart(handshakeStart),
        .cmdBusy(cmdBusy),
        .nrfdHold(nrfdHold)
    );

    // every queue entry is one group, so each word carries its delimiter
    assign rdData = ramIf.rdData;
    assign rdValid = rdValid_q;
    assign rdDelim = rdValid_q;
    assign statusByte = stb_q;
    assign devEventClear = devClr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic quiet;
    assign quiet = (errSet == 8'h00) && !talkerEarly && !listenerEarly && !rdReq
        && !respValid && (opc_q == gser_pkg::OPC_IDLE);

    sequence sClearQuiet;
        isClear && quiet;
    endsequence
    sequence sEsrReadQuiet;
        esrRead && quiet && (cnt_q != gser_pkg::OQ_FULL);
    endsequence
    sequence sErrReadQuiet;
        errRead && quiet && (cnt_q != gser_pkg::OQ_FULL);
    endsequence
    sequence sOpcDrain;
        (opc_q == gser_pkg::OPC_WAIT) && !opsPending && !isClear && !esrRead;
    endsequence

    a_esb_summary: assert property (statusByte[5] == |(esr_q & ese_q))
        else $error("summary bit disagrees with enabled events");
    a_clear_all: assert property (sClearQuiet |=> (esr_q == 8'h00) && (err_q == 8'h00)
        && devEventClear)
        else $error("clear left status flags set");
    a_mask_load: assert property ((cmdValid && cmdCode == gser_pkg::CMD_ESE_SET
        && !paramFormatFault && !valueRangeFault) |=> ese_q == ($past(cmdParam) & 8'hBD))
        else $error("enable mask not loaded");
    a_mask_keep: assert property ((cmdValid && cmdCode == gser_pkg::CMD_ESE_SET
        && paramFormatFault) |=> $stable(ese_q))
        else $error("faulty mask write took effect");
    a_esr_query: assert property (sEsrReadQuiet |-> push && (pushData == esr_q)
        ##1 ((esr_q & 8'hF7) == 8'h00))
        else $error("event query did not return then clear");
    a_err_query: assert property (sErrReadQuiet |-> push && (pushData == err_q)
        ##1 (err_q == 8'h00))
        else $error("fault query did not return then clear");
    a_pon_drop: assert property ($fell(esr_q[7]) |-> $past(isClear || esrRead))
        else $error("power-on flag lost without read");
    a_cmd_error: assert property ((msgLengthFault || headerUnknownFault || paramFormatFault)
        |=> esr_q[5] && (err_q[6:4] != 3'b000))
        else $error("command error not raised");
    a_exe_error: assert property ((valueRangeFault || notExecutableFault)
        |=> esr_q[4] && (err_q[3:2] != 2'b00))
        else $error("execution error not raised");
    a_dde_level: assert property (esr_q[3] == (err_q[1] || err_q[0]))
        else $error("device error not following its causes");
    a_query_error: assert property ((emptyRead || overflow || talkerEarly || listenerEarly)
        |=> esr_q[2])
        else $error("query error not raised");
    a_opc_done: assert property (sOpcDrain |=> esr_q[0] && (opc_q == gser_pkg::OPC_IDLE))
        else $error("operation complete not flagged");
    a_unused_zero: assert property ((esr_q[6] == 1'b0) && (esr_q[1] == 1'b0)
        && (err_q[7] == 1'b0))
        else $error("unused flag position set");
    a_mav_level: assert property (statusByte[4] == (cnt_q != 5'h00))
        else $error("message available out of step with queue");
    a_read_delim: assert property (pop |=> rdValid && rdDelim)
        else $error("read word without delimiter");
endmodule

// >>> gser_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus controller model: command issue and queue readout
// ------------------------------------------------------------
module gser_ctrl_model (
    // clock
    input wire logic clock,
    // command side
    output logic cmdValid,
    output gser_pkg::gser_cmd_t cmdCode,
    output logic [7:0] cmdParam,
    // queue readout
    output logic rdReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic rdDelim
);
    // idle bus at time zero
    initial begin
        cmdValid = 1'b0;
        cmdCode = gser_pkg::CMD_NONE;
        cmdParam = 8'h00;
        rdReq = 1'b0;
    end

    // commands chained one after another like one message line
    task automatic sendCmd(input gser_pkg::gser_cmd_t code, input logic [7:0] param);
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdParam <= param;
        @(posedge clock);
        cmdValid <= 1'b0;
        cmdCode <= gser_pkg::CMD_NONE;
        cmdParam <= ~param; // stale parameter never looks valid
    endtask

    // one group per read, sampled once the answer edge has landed
    task automatic readGroup(output logic [7:0] data, output logic gotIt);
        @(posedge clock);
        rdReq <= 1'b1;
        @(posedge clock);
        rdReq <= 1'b0;
        #1;
        gotIt = rdValid & rdDelim;
        data = rdData;
    endtask
endmodule

// >>> tb_gpib_status_event_regs.sv
`timescale 1ns/1ps
module tb_gpib_status_event_regs;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cmdValid, rdReq, rdValid, rdDelim, devEventClear, nrfdHold;
    gser_pkg::gser_cmd_t cmdCode;
    logic [7:0] cmdParam, rdData, statusByte;
    logic [6:0] faults = 7'h00; // index equals fault flag position
    logic [1:0] early = 2'b00;
    logic opsPending = 1'b0;
    logic cmdBusy = 1'b0;
    logic handshakeStart = 1'b0;
    logic respValid = 1'b0;
    logic [7:0] respData = 8'h00;
    int failCount = 0;
    int nTests = 0;
    int cycles = 0;

    // 40 MHz clock
    always #12.5 clock = ~clock;

    // ------------------------------------------------------------
    // design and controller model
    // ------------------------------------------------------------
    gser_top dut (.clock(clock), .rst_b(rst_b), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdParam(cmdParam), .msgLengthFault(faults[6]), .headerUnknownFault(faults[5]),
        .paramFormatFault(faults[4]), .valueRangeFault(faults[3]),
        .notExecutableFault(faults[2]), .internalLinkFault(faults[1]),
        .backupStoreLost(faults[0]), .talkerEarly(early[0]), .listenerEarly(early[1]),
        .opsPending(opsPending), .cmdBusy(cmdBusy), .handshakeStart(handshakeStart),
        .respValid(respValid), .respData(respData), .rdReq(rdReq), .rdData(rdData),
        .rdValid(rdValid), .rdDelim(rdDelim), .statusByte(statusByte),
        .devEventClear(devEventClear), .nrfdHold(nrfdHold));

    gser_ctrl_model ctrl (.clock(clock), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdParam(cmdParam), .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid),
        .rdDelim(rdDelim));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic expectRead(input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        ctrl.readGroup(d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask

    task automatic query(input gser_pkg::gser_cmd_t c, input logic [7:0] exp);
        ctrl.sendCmd(c, 8'h00);
        expectRead(exp);
    endtask

    task automatic pulseFaults(input logic [6:0] f);
        @(posedge clock);
        faults <= f;
        @(posedge clock);
        faults <= 7'h00;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // power-on flag reported once, then gone; queue flag follows data
    task automatic sPowerOn();
        chk(statusByte, 8'h00);
        ctrl.sendCmd(gser_pkg::CMD_ESR_QRY, 8'h00);
        repeat (2) @(posedge clock);
        chk(statusByte, 8'h10);
        expectRead(8'h80);
        @(posedge clock);
        chk(statusByte, 8'h00);
        query(gser_pkg::CMD_ESR_QRY, 8'h00);
        query(gser_pkg::CMD_ERR_QRY, 8'h00);
    endtask

    // every fault cause lands at its own bit and its event group, unmasked
    task automatic sFaults();
        logic [7:0] ev;
        for (int i = 0; i < 7; i++) begin
            ev = (i >= 4) ? 8'h20 : ((i >= 2) ? 8'h10 : 8'h08);
            pulseFaults(7'h01 << i);
            query(gser_pkg::CMD_ESR_QRY, ev);
            query(gser_pkg::CMD_ERR_QRY, 8'h01 << i);
            query(gser_pkg::CMD_ESR_QRY, 8'h00);
        end
    endtask

    // mask write and readback, malformed set ignored, summary, clear
    task automatic sMask();
        ctrl.sendCmd(gser_pkg::CMD_ESE_SET, 8'hFF);
        query(gser_pkg::CMD_ESE_QRY, 8'hBD);
        ctrl.sendCmd(gser_pkg::CMD_ESE_SET, 8'h10);
        fork
            pulseFaults(7'h10);
            ctrl.sendCmd(gser_pkg::CMD_ESE_SET, 8'h20);
        join
        query(gser_pkg::CMD_ESE_QRY, 8'h10);
        chk(statusByte, 8'h00);
        pulseFaults(7'h08);
        repeat (2) @(posedge clock);
        chk(statusByte, 8'h20);
        @(posedge clock);
        respValid <= 1'b1;
        respData <= 8'hA5;
        @(posedge clock);
        respValid <= 1'b0;
        expectRead(8'hA5);
        ctrl.sendCmd(gser_pkg::CMD_CLEAR, 8'h00);
        #1;
        chk({7'h00, devEventClear}, 8'h01);
        repeat (2) @(posedge clock);
        chk(statusByte, 8'h00);
        query(gser_pkg::CMD_ESR_QRY, 8'h00);
        query(gser_pkg::CMD_ERR_QRY, 8'h00);
    endtask

    // overflow, empty read and early addressing each raise query error
    task automatic sQueryErr();
        logic [7:0] d;
        logic ok;
        for (int i = 0; i < 17; i++) begin
            ctrl.sendCmd(gser_pkg::CMD_ESE_QRY, 8'h00);
        end
        for (int i = 0; i < 16; i++) begin
            expectRead(8'h10);
        end
        query(gser_pkg::CMD_ESR_QRY, 8'h04);
        ctrl.readGroup(d, ok);
        chk({7'h00, ok}, 8'h00);
        query(gser_pkg::CMD_ESR_QRY, 8'h04);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            early <= 2'b01 << i;
            @(posedge clock);
            early <= 2'b00;
            query(gser_pkg::CMD_ESR_QRY, 8'h04);
        end
    endtask

    // completion flag waits for pending work to drain
    task automatic sOpc();
        @(posedge clock);
        opsPending <= 1'b1;
        ctrl.sendCmd(gser_pkg::CMD_OPC, 8'h00);
        repeat (4) @(posedge clock);
        query(gser_pkg::CMD_ESR_QRY, 8'h00);
        @(posedge clock);
        opsPending <= 1'b0;
        repeat (2) @(posedge clock);
        query(gser_pkg::CMD_ESR_QRY, 8'h01);
    endtask

    // not-ready line held only while a command is still busy
    task automatic sNrfd();
        @(posedge clock);
        handshakeStart <= 1'b1;
        @(posedge clock);
        handshakeStart <= 1'b0;
        repeat (2) @(posedge clock);
        chk({7'h00, nrfdHold}, 8'h00);
        cmdBusy <= 1'b1;
        handshakeStart <= 1'b1;
        @(posedge clock);
        handshakeStart <= 1'b0;
        repeat (6) @(posedge clock);
        chk({7'h00, nrfdHold}, 8'h01);
        cmdBusy <= 1'b0;
        repeat (3) @(posedge clock);
        chk({7'h00, nrfdHold}, 8'h00);
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        sPowerOn();
        sFaults();
        sMask();
        sQueryErr();
        sOpc();
        sNrfd();
        printVerdict();
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            printVerdict();
        end
    end
endmodule
